// ### hw/bit_sync.sv
// Two flip-flop synchroniser for independent single-bit levels
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    // Each bit keeps its own pair of flops so no variable has two writers
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic first;
            logic second;

            // Resets to the bus idle level so no false edge follows reset
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    first  <= 1'b1;
                    second <= 1'b1;
                end else begin
                    first  <= async_in[i];
                    second <= first;
                end
            end
            assign sync_out[i] = second;
        end
    endgenerate
endmodule : bit_sync
`default_nettype wire

// ### hw/fifo_buffer.sv
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none
module fifo_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready    = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) ||
                      (wr_ptr[AW] == rd_ptr[AW]);
        out_valid   = (wr_ptr != rd_ptr);
        out_data    = mem[rd_ptr[AW-1:0]];
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage needs no reset; only written slots are ever read
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule : fifo_buffer
`default_nettype wire

// ### hw/i2c_port_pkg.sv
// Shared constants and state codes for the two-wire slave register port
`default_nettype none
package i2c_port_pkg;
    localparam int          BYTE_W         = 8;
    localparam logic [3:0]  BYTE_BITS      = 4'h8;
    localparam logic [7:0]  ADDR_SEL_LOW   = 8'h82;
    localparam logic [7:0]  ADDR_SEL_HIGH  = 8'h88;
    localparam logic [7:0]  COUNTER_RESET  = 8'h00;
    localparam logic [7:0]  ROLLOVER_ADDR  = 8'h00;
    localparam logic [1:0]  STRAP_WAIT     = 2'h2;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          FIFO_WIDTH     = 16;
    localparam int          SYNC_STAGES    = 2;
    // Bus rate limits and the oversampling they leave at the core clock
    localparam int          CLK_MHZ        = 100;
    localparam int          STD_RATE_KBPS  = 100;
    localparam int          FAST_RATE_KBPS = 400;
    localparam int          FAST_BIT_CYCLES = (CLK_MHZ * 1000) / FAST_RATE_KBPS;
    localparam int          STD_BIT_CYCLES  = (CLK_MHZ * 1000) / STD_RATE_KBPS;

    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_ADDR      = 9'h002,
        ST_ADDR_ACK  = 9'h004,
        ST_REG       = 9'h008,
        ST_REG_ACK   = 9'h010,
        ST_WDATA     = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA     = 9'h080,
        ST_RDATA_ACK = 9'h100
    } slave_state_t;
endpackage : i2c_port_pkg
`default_nettype wire

// ### hw/i2c_slave_register_port.sv
// Two-wire slave port: strap selection, framing, address counter, writes
//
// What this block does
// [RULE1] Mode strap at reset picks two-wire or SPI
// [RULE2] Address 0x82 or 0x88 from select pin
// [RULE3] Direction bit one reads, zero writes
// [RULE4] Ack own address, else ignore transaction
// [RULE5] Start is data fall with clock high
// [RULE6] Stop is data rise, returns to idle
// [RULE7] Stop ends register writes until new write
// [RULE8] Transmitter releases; receiver acks ninth bit
// [RULE9] Sample data on clock rising edges
// [RULE10] Master reads via address write, restart
// [RULE11] Slave sends another byte per master ack
// [RULE12] Master no-ack ends read, back to idle
// [RULE13] Incrementing reads advance, wrap to 0x00
// [RULE14] Fixed range keeps counter still
// [RULE15] Each written data byte is acknowledged while the buffer has room; a byte that finds it full is not acked
// [RULE16] Writes wrap after last register address
// [RULE17] Works up to 400 Kbps bus rate
// [RULE18] Increment ranges come from a parameter table
`default_nettype none
module i2c_slave_register_port #(
    parameter logic [255:0] AUTO_INCR_MAP = {256{1'b1}},
    parameter logic [7:0]   LAST_REG_ADDR = 8'hFF
) (
    input  wire logic                            mclk,
    input  wire logic                            resetn,
    input  wire logic                            interface_select_pin,
    input  wire logic                            address_select_pin,
    input  wire logic                            scl_pin,
    input  wire logic                            sda_in,
    output logic                                 sda_out,
    output logic                                 sda_oe_n,
    output logic                                 spi_selected,
    output logic [i2c_port_pkg::BYTE_W-1:0]      rd_addr,
    input  wire logic [i2c_port_pkg::BYTE_W-1:0] rd_data,
    output logic                                 rd_strobe,
    output logic                                 wr_valid,
    input  wire logic                            wr_ready,
    output logic [i2c_port_pkg::BYTE_W-1:0]      wr_addr,
    output logic [i2c_port_pkg::BYTE_W-1:0]      wr_data
);
    import i2c_port_pkg::*;

    logic [3:0]   pins_s;
    logic         scl_s, sda_s;
    logic         mode_s;
    logic         asel_s;
    logic         scl_q, sda_q;
    logic         scl_rise, scl_fall;
    logic         start_seen, stop_seen;
    logic [1:0]   strap_cnt, next_strap_cnt;
    logic         strap_done, next_strap_done;
    logic         next_spi_selected;
    logic         bus_address_select, next_bus_address_select;
    logic         active;
    logic [7:0]   own_addr;
    slave_state_t state, next_state;
    logic [3:0]   bitcnt, next_bitcnt;
    logic [7:0]   shreg, next_shreg;
    logic [7:0]   tx, next_tx;
    logic [7:0]   counter, next_counter;
    logic         rw, next_rw;
    logic         master_ack, next_master_ack;
    logic         refuse, next_refuse;
    logic         next_oe_n;
    logic         push;
    logic         fifo_in_ready;
    logic [15:0]  fifo_out_data;

    function automatic logic [7:0] next_address(input logic [7:0] a);
        if (!AUTO_INCR_MAP[a]) begin
            return a; // RULE14 RULE18
        end else if (a == LAST_REG_ADDR) begin
            return ROLLOVER_ADDR; // RULE13 RULE16
        end else begin
            return a + 8'h01; // RULE13
        end
    endfunction : next_address

    // Straps and bus lines share one synchroniser; 250 samples per bit
    // at the fastest rate leave ample margin for the two-cycle lag
    bit_sync #(.WIDTH(SYNC_STAGES * 2)) u_sync ( // RULE17
        .mclk     (mclk),
        .resetn   (resetn),
        .async_in ({interface_select_pin, address_select_pin,
                    scl_pin, sda_in}),
        .sync_out (pins_s)
    );
    assign mode_s = pins_s[3];
    assign asel_s = pins_s[2];
    assign scl_s  = pins_s[1];
    assign sda_s  = pins_s[0];

    fifo_buffer #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({counter, shreg}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out_data)
    );
    assign wr_addr = fifo_out_data[15:8];
    assign wr_data = fifo_out_data[7:0];

    always_comb begin
        scl_rise   = scl_s && !scl_q; // RULE9
        scl_fall   = !scl_s && scl_q;
        start_seen = scl_s && scl_q && sda_q && !sda_s; // RULE5
        stop_seen  = scl_s && scl_q && !sda_q && sda_s; // RULE6
    end

    // Straps are caught once the synchroniser holds post-reset values
    always_comb begin
        next_strap_cnt          = strap_cnt;
        next_strap_done         = strap_done;
        next_spi_selected       = spi_selected;
        next_bus_address_select = bus_address_select;
        if (!strap_done) begin
            if (strap_cnt == STRAP_WAIT) begin
                next_strap_done         = 1'b1;
                next_spi_selected       = mode_s; // RULE1
                next_bus_address_select = asel_s;
            end else begin
                next_strap_cnt = strap_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strap_cnt          <= 2'h0;
            strap_done         <= 1'b0;
            spi_selected       <= 1'b0;
            bus_address_select <= 1'b0;
            scl_q              <= 1'b1;
            sda_q              <= 1'b1;
        end else begin
            strap_cnt          <= next_strap_cnt;
            strap_done         <= next_strap_done;
            spi_selected       <= next_spi_selected;
            bus_address_select <= next_bus_address_select;
            scl_q              <= scl_s;
            sda_q              <= sda_s;
        end
    end

    assign active   = strap_done && !spi_selected; // RULE1
    assign own_addr = bus_address_select ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
    assign sda_out  = 1'b0;
    assign rd_addr  = counter;

    always_comb begin
        next_state      = state;
        next_bitcnt     = bitcnt;
        next_shreg      = shreg;
        next_tx         = tx;
        next_counter    = counter;
        next_rw         = rw;
        next_master_ack = master_ack;
        next_refuse     = refuse;
        next_oe_n       = sda_oe_n;
        push            = 1'b0;
        rd_strobe       = 1'b0;
        if (!active) begin
            next_state = ST_IDLE;
            next_oe_n  = 1'b1;
        end else if (stop_seen) begin
            next_state = ST_IDLE; // RULE6 RULE7
            next_oe_n  = 1'b1;
        end else if (start_seen) begin
            next_state  = ST_ADDR; // RULE5
            next_bitcnt = 4'h0;
            next_oe_n   = 1'b1;
        end else begin
            unique case (state)
                ST_IDLE: begin
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise && bitcnt != BYTE_BITS) begin
                        next_shreg  = {shreg[6:0], sda_s}; // RULE9
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == BYTE_BITS) begin
                        next_bitcnt = 4'h0;
                        if (state == ST_ADDR) begin
                            if (shreg[7:1] == own_addr[7:1]) begin
                                next_state = ST_ADDR_ACK; // RULE2 RULE4
                                next_oe_n  = 1'b0;
                                next_rw    = shreg[0]; // RULE3
                            end else begin
                                next_state = ST_IDLE; // RULE4
                            end
                        end else if (state == ST_REG) begin
                            next_counter = shreg;
                            next_state   = ST_REG_ACK;
                            next_oe_n    = 1'b0;
                        end else if (fifo_in_ready) begin
                            push         = 1'b1; // RULE15
                            next_counter = next_address(counter); // RULE16
                            next_state   = ST_WDATA_ACK;
                            next_oe_n    = 1'b0;
                            next_refuse  = 1'b0;
                        end else begin
                            // Full buffer: decline the byte rather than lose it
                            next_state  = ST_WDATA_ACK;
                            next_refuse = 1'b1;
                        end
                    end
                end
                ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_oe_n = 1'b1; // RULE8
                        if (state == ST_ADDR_ACK && rw) begin
                            rd_strobe  = 1'b1; // RULE10
                            next_tx    = rd_data;
                            next_oe_n  = rd_data[7];
                            next_state = ST_RDATA;
                        end else if (state == ST_ADDR_ACK) begin
                            next_state = ST_REG; // RULE10
                        end else if (state == ST_WDATA_ACK && refuse) begin
                            next_state = ST_IDLE;
                        end else begin
                            next_state = ST_WDATA; // RULE15
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise && bitcnt != BYTE_BITS) begin
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == BYTE_BITS) begin
                        next_bitcnt  = 4'h0;
                        next_oe_n    = 1'b1; // RULE8
                        next_counter = next_address(counter); // RULE13
                        next_state   = ST_RDATA_ACK;
                    end else if (scl_fall) begin
                        next_tx   = {tx[6:0], 1'b0};
                        next_oe_n = tx[6];
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        next_master_ack = !sda_s; // RULE8
                    end else if (scl_fall && master_ack) begin
                        rd_strobe  = 1'b1; // RULE11
                        next_tx    = rd_data;
                        next_oe_n  = rd_data[7];
                        next_state = ST_RDATA;
                    end else if (scl_fall) begin
                        next_state = ST_IDLE; // RULE12
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state      <= ST_IDLE;
            bitcnt     <= 4'h0;
            shreg      <= 8'h00;
            tx         <= 8'h00;
            counter    <= COUNTER_RESET;
            rw         <= 1'b0;
            master_ack <= 1'b0;
            refuse     <= 1'b0;
            sda_oe_n   <= 1'b1;
        end else begin
            state      <= next_state;
            bitcnt     <= next_bitcnt;
            shreg      <= next_shreg;
            tx         <= next_tx;
            counter    <= next_counter;
            rw         <= next_rw;
            master_ack <= next_master_ack;
            refuse     <= next_refuse;
            sda_oe_n   <= next_oe_n;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    strap_capture_a: assert property ($rose(strap_done) |->  // RULE1
        spi_selected == $past(mode_s))
        else $error("mode strap not captured");
    addr_mismatch_a: assert property (state == ST_ADDR && scl_fall && // RULE4
        bitcnt == BYTE_BITS && shreg[7:1] != own_addr[7:1] &&
        !start_seen && !stop_seen |=> state == ST_IDLE && sda_oe_n)
        else $error("foreign address not ignored");
    addr_ack_a: assert property (state == ST_ADDR && scl_fall && // RULE2
        bitcnt == BYTE_BITS && shreg[7:1] == own_addr[7:1] &&
        !start_seen && !stop_seen |=> !sda_oe_n && rw == $past(shreg[0]))
        else $error("own address not acknowledged");
    start_detect_a: assert property (active && start_seen && // RULE5
        !stop_seen |=> state == ST_ADDR && bitcnt == 4'h0)
        else $error("start not taken");
    stop_idle_a: assert property (active && stop_seen |=> // RULE6
        state == ST_IDLE ##1 !push [*2])
        else $error("stop did not return to idle");
    idle_no_write_a: assert property (state == ST_IDLE |-> !push) // RULE7
        else $error("register write outside a write");
    read_release_a: assert property (state == ST_RDATA_ACK |-> // RULE8
        sda_oe_n)
        else $error("line held during master ack bit");
    sample_rise_a: assert property (state == ST_WDATA && scl_rise && // RULE9
        bitcnt != BYTE_BITS && !start_seen && !stop_seen |=>
        shreg[0] == $past(sda_s) && bitcnt == $past(bitcnt) + 4'h1)
        else $error("data bit not sampled on rise");
    nack_idle_a: assert property (state == ST_RDATA_ACK && scl_fall && // RULE12
        !master_ack && !start_seen && !stop_seen |=> state == ST_IDLE)
        else $error("read did not end on no-ack");
    ack_more_a: assert property (state == ST_RDATA_ACK && scl_fall && // RULE11
        master_ack && !start_seen && !stop_seen |=>
        state == ST_RDATA && sda_oe_n == $past(rd_data[7]))
        else $error("next read byte not started");
    wrap_addr_a: assert property (state == ST_RDATA && scl_fall && // RULE13
        bitcnt == BYTE_BITS && counter == LAST_REG_ADDR &&
        AUTO_INCR_MAP[counter] && !start_seen && !stop_seen |=>
        counter == ROLLOVER_ADDR)
        else $error("counter did not roll over");
    fixed_addr_a: assert property (push && !AUTO_INCR_MAP[counter] // RULE14
        |=> $stable(counter))
        else $error("fixed address moved");
    write_ack_a: assert property (push |=> state == ST_WDATA_ACK && // RULE15
        !sda_oe_n)
        else $error("written byte not acknowledged");

    read_cover_c: cover property (state == ST_RDATA_ACK && scl_fall &&
        master_ack);
    write_cover_c: cover property (push ##[1:1000] push);
    refuse_cover_c: cover property (state == ST_WDATA_ACK && refuse);
    wrap_cover_c: cover property (push && counter == LAST_REG_ADDR);
endmodule : i2c_slave_register_port
`default_nettype wire

// ### tb/i2c_master_model.sv
// Behavioural two-wire bus master that drives the clock and pulls data low
`default_nettype none
module i2c_master_model (
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    timeunit 1ns;
    timeprecision 1ns;

    // Clock idles high between frames and data is released to the pull-up
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // Start or repeated start; works from idle and from a low clock
    task automatic start();
        #40 sda_low = 1'b0;
        #40 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
    endtask : start

    // Eight bits MSB first, then the ninth bit; a one there releases
    task automatic xfer(input  logic [7:0] d,
                        input  logic       ninth,
                        output logic [8:0] seen);
        logic [8:0] s;
        s = {d, ninth};
        for (int i = 8; i >= 0; i--) begin
            #40 sda_low = ~s[i];
            #40 scl = 1'b1;
            #40 seen[i] = sda;
            #40 scl = 1'b0;
        end
    endtask : xfer

    task automatic stop();
        #40 sda_low = 1'b1;
        #40 scl = 1'b1;
        #40 sda_low = 1'b0;
        #40;
    endtask : stop
endmodule : i2c_master_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the two-wire slave register port
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
    miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); \
    end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import i2c_port_pkg::*;

    logic              mclk = 1'b0;
    logic              resetn = 1'b0;
    logic              interface_select_pin = 1'b0;
    logic              address_select_pin = 1'b0;
    logic              wr_ready = 1'b0;
    logic              stall = 1'b1;
    logic              sda_low, scl_pin, sda_out, sda_oe_n;
    logic              spi_selected, rd_strobe, wr_valid;
    logic [BYTE_W-1:0] rd_addr, rd_data, wr_addr, wr_data;
    wire logic         sda;
    logic [7:0]        regs [256];
    logic [15:0]       wq [$];
    logic [8:0]        seen;
    int                miscompares = 0;
    int                tests_run = 0;
    int                strobes = 0;

    always #5 mclk = ~mclk;
    // Open-drain data wire with a pull-up
    assign sda = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
    assign rd_data = regs[rd_addr];
    // Consumer takes a word only every other cycle, and none while stall is high, so the buffer backs up
    always @(negedge mclk) wr_ready <= ~stall & ~wr_ready;
    always @(posedge mclk) begin
        if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
    end
    // Counts the register fetches the slave makes while it transmits
    always @(posedge mclk) begin
        if (rd_strobe === 1'b1) strobes++;
    end

    i2c_slave_register_port #(
        .AUTO_INCR_MAP(~(256'h1 << 16)),
        .LAST_REG_ADDR(8'h07)
    ) i2c_slave_register_port_inst (
        .mclk, .resetn, .interface_select_pin, .address_select_pin,
        .scl_pin, .sda_in(sda), .sda_out, .sda_oe_n, .spi_selected,
        .rd_addr, .rd_data, .rd_strobe, .wr_valid, .wr_ready,
        .wr_addr, .wr_data
    );

    i2c_master_model i2c_master_model_inst (
        .sda, .scl(scl_pin), .sda_low
    );

    task automatic do_reset(input logic m, input logic a);
        @(negedge mclk);
        resetn = 1'b0;
        interface_select_pin = m;
        address_select_pin = a;
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        repeat (10) @(negedge mclk);
    endtask : do_reset

    task automatic sta();
        i2c_master_model_inst.start();
    endtask : sta

    task automatic sto();
        i2c_master_model_inst.stop();
    endtask : sto

    // Sends one byte and checks the ninth bit against the expected ack
    task automatic wb(input logic [7:0] d, input logic ack);
        i2c_master_model_inst.xfer(d, 1'b1, seen);
        `CHK(seen[0], ~ack)
    endtask : wb

    task automatic s_strap();
        do_reset(1'b1, 1'b0);
        `CHK(spi_selected, 1'b1)
        sta();
        wb(8'h82, 1'b0);
        sto();
        do_reset(1'b0, 1'b1);
        `CHK(spi_selected, 1'b0)
        sta();
        wb(8'h82, 1'b0);
        sta();
        wb(8'h88, 1'b1);
        sto();
        do_reset(1'b0, 1'b0);
    endtask : s_strap

    task automatic s_write();
        wq.delete();
        stall = 1'b0;
        sta();
        wb(8'h82, 1'b1);
        wb(8'h05, 1'b1);
        for (int i = 0; i < 4; i++) wb(8'hA0 + 8'(i), 1'b1);
        sto();
        sta();
        wb(8'h82, 1'b1);
        wb(8'h10, 1'b1);
        for (int i = 0; i < 3; i++) wb(8'h30 + 8'(i), 1'b1);
        sto();
        // A foreign address after the stop must not reach the registers
        sta();
        wb(8'h88, 1'b0);
        wb(8'h55, 1'b0);
        sto();
        repeat (40) @(negedge mclk);
        `CHK(wq.size(), 7)
        for (int i = 0; i < 4; i++) begin
            `CHK(wq[i], {8'((i + 5) % 8), 8'hA0 + 8'(i)})
        end
        for (int i = 0; i < 3; i++) begin
            `CHK(wq[4 + i], {8'h10, 8'h30 + 8'(i)})
        end
    endtask : s_write

    task automatic s_read();
        int s0;
        s0 = strobes;
        sta();
        wb(8'h82, 1'b1);
        wb(8'h06, 1'b1);
        sta();
        wb(8'h83, 1'b1);
        for (int i = 0; i < 3; i++) begin
            i2c_master_model_inst.xfer(8'hFF, i == 2, seen);
            `CHK(seen[8:1], regs[(i + 6) % 8])
        end
        // After the master's no-ack the slave must leave the wire alone
        i2c_master_model_inst.xfer(8'hFF, 1'b1, seen);
        `CHK(seen, 9'h1FF)
        `CHK(strobes - s0, 3)
        sto();
    endtask : s_read

    task automatic s_fifo();
        stall = 1'b1;
        repeat (4) @(negedge mclk);
        wq.delete();
        sta();
        wb(8'h82, 1'b1);
        wb(8'h00, 1'b1);
        for (int i = 0; i < 9; i++) wb(8'h40 + 8'(i), i < 8);
        sto();
        `CHK(wr_valid, 1'b1)
        stall = 1'b0;
        for (int i = 0; i < 200 && wr_valid; i++) @(negedge mclk);
        `CHK(wr_valid, 1'b0)
        `CHK(wq.size(), 8)
        foreach (wq[i]) `CHK(wq[i], {8'(i), 8'h40 + 8'(i)})
    endtask : s_fifo

    task automatic end_of_test();
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        foreach (regs[i]) regs[i] = 8'(i) ^ 8'hC3;
        s_strap();
        s_write();
        s_read();
        s_fifo();
        end_of_test();
    end

    // The tests need well under 150 us; a hang stops at 500 us
    initial begin
        #500000;
        miscompares++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
